// ---- rtcpw_core.sv ----
// rtc core: calendar, alarm, watchdog, clock out, power control
// Operation
// - at reset release latch single-supply if system sense high, else backup
// - single-supply: enable clock out, supply enable and host reset
// - single-supply: host reset low whenever system sense is low
// - backup: outputs low until system sense rises, then enabled
// - backup: outputs low whenever system sense drops
// - counters advance once per 1 Hz tick from crystal or line
// - seven bcd counters at 20h-26h, hours carry 12/24 and pm
// - 32 byte ram at 00h-1fh, chosen by address bit 5 low
// - alarm latches compared to time; match sets alarm status
// - alarm drives interrupt only while alarm enable is set
// - missed toggle pulses host reset and sets status bit 6
// - service within 7.8 ms, reset after 15.6 ms on crystal
// - clock control low bits pick one of seven rates or low
// - rates have 50 percent duty except 2 Hz on 50 Hz base
// - control registers read and write; status read only
// - power sense: line_in_window_i high for 2.68 ms raises power fail
// - line held inside window 2.68 ms counts as power failure
// - power-down bit drops outputs and disables serial writes
// - any interrupt ends power-down
// - system sense low then high also ends power-down
// - interrupt holds until status read or its enable bit cleared; read clears power-down
// - alarm flag and interrupt delayed 30.5 us after match
// - clock out codes 0..7 as listed, reset selects crystal
`timescale 1ns/1ns
`default_nettype none
module rtcpw_core
  import rtcpw_pkg::*;
#(
  parameter int PF_CYC = PF_MIN_CYC,
  parameter int WD_CYC = WD_RST_CYC,
  parameter int CW = 20
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic system_sense_in_i,
  input wire logic line_in_window_i,
  input wire logic line_i,
  input wire logic crystal_ref_i,
  input wire logic chip_en_i,
  output logic supply_enable_out_o,
  output logic host_reset_n_o,
  output logic host_reset_oe_o,
  output logic int_n_o,
  output logic int_oe_o,
  output logic sq_wave_o
);
  // ********************
  // helpers
  // ********************
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      return {v[7:4] + 4'h1, 4'h0};
    end
    return {v[7:4], v[3:0] + 4'h1};
  endfunction

  function automatic logic [7:0] month_days(input logic [7:0] m,
                                            input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    case (m)
      8'h02: return leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
      default: return 8'h31;
    endcase
  endfunction

  function automatic logic sq_half(input logic [22:0] cnt,
                                   input logic [22:0] per);
    logic [22:0] m;
    m = cnt & (per - 23'h1);
    return m < (per >> 1);
  endfunction

  // ********************
  // state
  // ********************
  logic [7:0] tm [0:6];
  logic [7:0] next_tm [0:6];
  logic [7:0] al [0:2];
  logic [7:0] next_al [0:2];
  logic [7:0] cctl, ictl, stat;
  logic [7:0] next_cctl, next_ictl, next_stat;
  logic [22:0] pre, next_pre;
  logic [5:0] lcnt, next_lcnt;
  logic xr_d, ln_d, ce_d, next_xr_d, next_ln_d, next_ce_d;
  logic tick_d, next_tick_d;
  logic [9:0] adly, next_adly;
  logic [CW-1:0] pfc, next_pfc, wdc, next_wdc;
  logic [4:0] wdp, next_wdp;
  logic pf_arm, next_pf_arm;
  logic mode_ok, single, next_mode_ok, next_single;
  logic pd, next_pd, sys_low_seen, next_sys_low_seen;
  logic int_d, next_int_d;
  logic ack, next_ack;
  logic [7:0] rd, next_rd;
  logic rd_ram, next_rd_ram;
  logic supply_enable_out, next_pse, hrn, next_hrn, intn, next_intn, sq, next_sq;
  logic [7:0] ram_q;

  logic req, wr_go, rd_go;
  logic [5:0] idx;
  logic [22:0] xhz;
  logic [5:0] lhz;
  logic x_rise, l_rise, tick, int_now, out_en;

  assign req = cyc_i & stb_i;
  assign idx = adr_i[7:2];
  // the write lands on the edge at which the master sees ack
  assign wr_go = req & ack & we_i & sel_i[0] & ~pd;
  assign rd_go = req & ack & ~we_i;

  rtcpw_ram #(.AW(5), .DW(8)) u_ram (
    .clk_i(clk_i),
    .en_i(en_i),
    .we_i(wr_go & ~idx[IDX_RAM_SEL]),
    .addr_i(idx[4:0]),
    .wdata_i(dat_i[7:0]),
    .rdata_o(ram_q)
  );

  // ********************
  // time base
  // ********************
  always_comb begin
    unique case (cctl[CC_XSEL+1:CC_XSEL])
      2'h0: xhz = CRYSTAL_REF_HZ0;
      2'h1: xhz = CRYSTAL_REF_HZ1;
      2'h2: xhz = CRYSTAL_REF_HZ2;
      2'h3: xhz = CRYSTAL_REF_HZ3;
    endcase
    lhz = cctl[CC_50HZ] ? LINE_HZ50 : LINE_HZ60;
    x_rise = crystal_ref_i & ~xr_d;
    // line prescaler is cut off while power sense owns the line
    l_rise = line_i & ~ln_d & ~ictl[IC_PSENSE];
    next_pre = pre;
    next_lcnt = lcnt;
    tick = 1'b0;
    if (x_rise) begin
      next_pre = (pre == xhz - 23'h1) ? 23'h0 : pre + 23'h1;
    end
    if (l_rise) begin
      next_lcnt = (lcnt == lhz - 6'h1) ? 6'h0 : lcnt + 6'h1;
    end
    if (cctl[CC_LINE]) begin
      tick = l_rise && lcnt == lhz - 6'h1;
    end else begin
      tick = x_rise && pre == xhz - 23'h1;
    end
    tick = tick & cctl[CC_START];
    next_xr_d = crystal_ref_i;
    next_ln_d = line_i;
  end

  // ********************
  // clock out
  // ********************
  logic sq_sel;
  logic [5:0] lh;
  always_comb begin
    lh = (lcnt >= (lhz >> 1)) ? lcnt - (lhz >> 1) : lcnt;
    sq_sel = 1'b0;
    unique case (cctl[2:0])
      SQ_CRYSTAL_REF: sq_sel = crystal_ref_i;
      SQ_DIV2: sq_sel = pre[0];
      SQ_DIV4: sq_sel = pre[1];
      SQ_DIV8: sq_sel = pre[2];
      SQ_LOW: sq_sel = 1'b0;
      SQ_1HZ: sq_sel = cctl[CC_START] & (cctl[CC_LINE] ?
                       lcnt < (lhz >> 1) : sq_half(pre, xhz));
      SQ_2HZ: sq_sel = cctl[CC_START] & (cctl[CC_LINE] ?
                       lh < (lhz >> 2) : sq_half(pre, xhz >> 1));
      SQ_LINE: sq_sel = cctl[CC_LINE] ? line_i :
                        sq_half(pre, xhz >> 6);
    endcase
  end

  // ********************
  // calendar, alarm and registers
  // ********************
  logic [7:0] h;
  logic day_roll, match;
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      next_tm[i] = tm[i];
    end
    for (int i = 0; i < 3; i++) begin
      next_al[i] = al[i];
    end
    next_cctl = cctl;
    next_ictl = ictl;
    next_stat = stat;
    day_roll = 1'b0;
    h = tm[2];
    if (tick) begin
      next_tm[0] = (tm[0] == 8'h59) ? 8'h00 : bcd_inc(tm[0]);
      if (tm[0] == 8'h59) begin
        next_tm[1] = (tm[1] == 8'h59) ? 8'h00 : bcd_inc(tm[1]);
        if (tm[1] == 8'h59) begin
          if (h[HR_12H]) begin
            if (h[4:0] == 5'h11) begin
              day_roll = h[HR_PM];
              next_tm[2] = {h[7:6], ~h[HR_PM], 5'h12};
            end else if (h[4:0] == 5'h12) begin
              next_tm[2] = {h[7:5], 5'h01};
            end else begin
              next_tm[2] = {h[7:5], 5'(bcd_inc({3'h0, h[4:0]}))};
            end
          end else begin
            day_roll = h == 8'h23;
            next_tm[2] = day_roll ? 8'h00 : bcd_inc(h);
          end
        end
      end
      if (day_roll) begin
        next_tm[3] = (tm[3] == 8'h07) ? 8'h01 : bcd_inc(tm[3]);
        if (tm[4] == month_days(tm[5], tm[6])) begin
          next_tm[4] = 8'h01;
          next_tm[5] = (tm[5] == 8'h12) ? 8'h01 : bcd_inc(tm[5]);
          if (tm[5] == 8'h12) begin
            next_tm[6] = (tm[6] == 8'h99) ? 8'h00 : bcd_inc(tm[6]);
          end
        end else begin
          next_tm[4] = bcd_inc(tm[4]);
        end
      end
    end
    match = al[0] == tm[0] && al[1] == tm[1] &&
            al[2][5:0] == tm[2][5:0];
    next_tick_d = tick;
    next_adly = adly;
    if (tick_d && match) begin
      next_adly = 10'(ALARM_DLY_CYC);
    end else if (adly != 10'h0) begin
      next_adly = adly - 10'h1;
    end
    // status read clears flags; a flag set in that cycle still wins
    if (rd_go && idx == IDX_STAT) begin
      next_stat = 8'h00;
    end
    if (adly == 10'h1) begin
      next_stat[ST_ALARM] = 1'b1;
    end
    if (pf_arm && ictl[IC_PSENSE] && pfc == CW'(PF_CYC - 1)) begin
      next_stat[ST_PFAIL] = 1'b1;
    end
    if (ictl[IC_WDOG] && wdc == CW'(WD_CYC - 1)) begin
      next_stat[ST_WDOG] = 1'b1;
    end
    next_stat[ST_INT] = (next_stat[ST_ALARM] & ictl[IC_ALARM]) |
                        (next_stat[ST_PFAIL] & ictl[IC_PSENSE]);
    if (wr_go) begin
      for (int i = 0; i < 7; i++) begin
        if (idx == IDX_SEC + 6'(i)) begin
          next_tm[i] = dat_i[7:0];
        end
      end
      for (int i = 0; i < 3; i++) begin
        if (idx == IDX_ASEC + 6'(i)) begin
          next_al[i] = dat_i[7:0];
        end
      end
      if (idx == IDX_CCTL) begin
        next_cctl = dat_i[7:0];
      end
      if (idx == IDX_ICTL) begin
        next_ictl = dat_i[7:0];
      end
    end
    if (pd && !next_pd) begin
      next_ictl[IC_PDOWN] = 1'b0;
    end
  end

  // ********************
  // watchdog and power sense
  // ********************
  always_comb begin
    next_ce_d = chip_en_i;
    next_wdc = wdc;
    next_wdp = wdp;
    if (!ictl[IC_WDOG] || chip_en_i != ce_d) begin
      next_wdc = '0;
    end else if (wdc == CW'(WD_CYC - 1)) begin
      next_wdc = '0;
      next_wdp = 5'(WD_PULSE_CYC);
    end else begin
      next_wdc = wdc + CW'(1);
    end
    if (wdp != 5'h0 && !(ictl[IC_WDOG] && wdc == CW'(WD_CYC - 1))) begin
      next_wdp = wdp - 5'h1;
    end
    next_pfc = '0;
    if (ictl[IC_PSENSE] && line_in_window_i && pf_arm) begin
      next_pfc = (pfc == CW'(PF_CYC - 1)) ? pfc : pfc + CW'(1);
    end
    next_pf_arm = pf_arm;
    if (pfc == CW'(PF_CYC - 1)) begin
      next_pf_arm = 1'b0;
    end
    if (!ictl[IC_PSENSE]) begin
      next_pf_arm = 1'b1;
    end
  end

  // ********************
  // mode and power-down
  // ********************
  always_comb begin
    next_mode_ok = 1'b1;
    next_single = mode_ok ? single : system_sense_in_i;
    int_now = stat[ST_INT];
    next_int_d = int_now;
    next_pd = pd;
    next_sys_low_seen = sys_low_seen;
    if (pd) begin
      if (!system_sense_in_i) begin
        next_sys_low_seen = 1'b1;
      end
      if (int_now && !int_d) begin
        next_pd = 1'b0;
      end
      if (sys_low_seen && system_sense_in_i) begin
        next_pd = 1'b0;
      end
      if (rd_go && idx == IDX_STAT) begin
        next_pd = 1'b0;
      end
    end else if (wr_go && idx == IDX_ICTL && dat_i[IC_PDOWN]) begin
      next_pd = 1'b1;
      next_sys_low_seen = 1'b0;
    end
    // outputs follow the release in the same cycle
    out_en = mode_ok & ~next_pd &
             (single | system_sense_in_i);
    next_pse = out_en;
    next_sq = out_en & sq_sel;
    next_hrn = out_en & system_sense_in_i & (next_wdp == 5'h0);
    next_intn = ~int_now;
  end

  // ********************
  // bus slave
  // ********************
  always_comb begin
    next_ack = req & ~ack;
    next_rd_ram = ~idx[IDX_RAM_SEL];
    next_rd = 8'h00;
    for (int i = 0; i < 7; i++) begin
      if (idx == IDX_SEC + 6'(i)) begin
        next_rd = tm[i];
      end
    end
    for (int i = 0; i < 3; i++) begin
      if (idx == IDX_ASEC + 6'(i)) begin
        next_rd = al[i];
      end
    end
    if (idx == IDX_STAT) begin
      next_rd = stat;
    end
    if (idx == IDX_CCTL) begin
      next_rd = cctl;
    end
    if (idx == IDX_ICTL) begin
      next_rd = ictl;
    end
    if (ack) begin
      next_rd = rd;
      next_rd_ram = rd_ram;
    end
  end

  assign ack_o = ack;
  assign dat_o = {24'h0, rd_ram ? ram_q : rd};
  assign supply_enable_out_o = supply_enable_out;
  assign host_reset_n_o = 1'b0;
  assign host_reset_oe_o = ~hrn;
  assign int_n_o = 1'b0;
  assign int_oe_o = ~intn;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 7; i++) begin
        tm[i] <= (i >= 3 && i <= 5) ? DAY_RST : TIME_RST;
      end
      for (int i = 0; i < 3; i++) begin
        al[i] <= TIME_RST;
      end
      cctl <= CC_RST;
      ictl <= IC_RST;
      stat <= ST_RST;
      pre <= '0;
      lcnt <= '0;
      xr_d <= 1'b0;
      ln_d <= 1'b0;
      ce_d <= 1'b0;
      tick_d <= 1'b0;
      adly <= '0;
      pfc <= '0;
      wdc <= '0;
      wdp <= '0;
      pf_arm <= 1'b1;
      mode_ok <= 1'b0;
      single <= 1'b0;
      pd <= 1'b0;
      sys_low_seen <= 1'b0;
      int_d <= 1'b0;
      ack <= 1'b0;
      rd <= 8'h00;
      rd_ram <= 1'b0;
      supply_enable_out <= 1'b0;
      hrn <= 1'b0;
      intn <= 1'b1;
      sq <= 1'b0;
    end else if (en_i) begin
      tm <= next_tm;
      al <= next_al;
      cctl <= next_cctl;
      ictl <= next_ictl;
      stat <= next_stat;
      pre <= next_pre;
      lcnt <= next_lcnt;
      xr_d <= next_xr_d;
      ln_d <= next_ln_d;
      ce_d <= next_ce_d;
      tick_d <= next_tick_d;
      adly <= next_adly;
      pfc <= next_pfc;
      wdc <= next_wdc;
      wdp <= next_wdp;
      pf_arm <= next_pf_arm;
      mode_ok <= next_mode_ok;
      single <= next_single;
      pd <= next_pd;
      sys_low_seen <= next_sys_low_seen;
      int_d <= next_int_d;
      ack <= next_ack;
      rd <= next_rd;
      rd_ram <= next_rd_ram;
      supply_enable_out <= next_pse;
      hrn <= next_hrn;
      intn <= next_intn;
      sq <= next_sq;
    end
  end

  assign sq_wave_o = sq;
endmodule
`default_nettype wire

// ---- rtcpw_core_chk.sv ----
// assertion checker for the rtc power and watchdog core
`timescale 1ns/1ns
`default_nettype none
module rtcpw_core_chk
  import rtcpw_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic system_sense_in_i,
  input wire logic supply_enable_out_o,
  input wire logic host_reset_oe_o,
  input wire logic int_oe_o,
  input wire logic sq_wave_o
);
  // ****
  // helper state: latched mode and clock-out code
  // ****
  logic started;
  logic single;
  logic [2:0] cc_code;
  logic next_started;
  logic next_single;
  logic [2:0] next_cc_code;
  logic wr_ack;
  logic rd_stat;
  assign wr_ack = cyc_i && stb_i && we_i && ack_o && sel_i[0];
  assign rd_stat = cyc_i && stb_i && !we_i && ack_o && adr_i[7:2] == IDX_STAT;
  always_comb begin
    next_started = 1'b1;
    next_single = started ? single : system_sense_in_i;
    next_cc_code = cc_code;
    if (wr_ack && adr_i[7:2] == IDX_CCTL) begin
      next_cc_code = dat_i[2:0];
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      started <= 1'b0;
      single <= 1'b1;
      cc_code <= SQ_CRYSTAL_REF;
    end else begin
      started <= next_started;
      single <= next_single;
      cc_code <= next_cc_code;
    end
  end
  // ****
  // properties
  // ****
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  chk_ack_one_cycle: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  chk_ack_reply: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acknowledged next cycle");
  chk_rd_upper_zero: assert property (ack_o && !we_i
    |-> dat_o[31:8] == 24'h0
    && (adr_i[7:2] != IDX_CCTL || dat_o[2:0] == cc_code))
    else $error("read data upper bits not zero");
  chk_sense_host_reset: assert property (started && !system_sense_in_i
    |=> host_reset_oe_o)
    else $error("host reset not asserted with system sense low");
  chk_backup_off: assert property (started && !single
    && !system_sense_in_i |=> !supply_enable_out_o && !sq_wave_o)
    else $error("backup outputs active with system sense low");
  chk_pdown_out: assert property (wr_ack && adr_i[7:2] == IDX_ICTL
    && dat_i[IC_PDOWN] |-> ##[1:2] (!supply_enable_out_o && host_reset_oe_o
    && !sq_wave_o))
    else $error("power-down did not drop outputs");
  chk_int_hold: assert property ($fell(int_oe_o)
    |-> $past(rd_stat) || $past(rd_stat, 2))
    else $error("interrupt released without status read");
  chk_sq_low_code: assert property (cc_code == SQ_LOW
    && $past(cc_code) == SQ_LOW |-> !sq_wave_o)
    else $error("clock out not low with low code");
endmodule
`default_nettype wire

// ---- rtcpw_host_env.sv ----
// far-side model: crystal source, line input and watchdog servicing
`timescale 1ns/1ns
`default_nettype none
module rtcpw_host_env (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic line_run_i,
  input wire logic wd_service_i,
  output logic crystal_ref_o,
  output logic line_o,
  output logic chip_en_o
);
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic next_ce;
  assign crystal_ref_o = cnt[1];
  // line stands low when stopped, 8 clocks a period when running
  assign line_o = line_run_i & cnt[2];
  always_comb begin
    next_cnt = cnt + 4'h1;
    next_ce = chip_en_o;
    // toggle chip enable with no transfer, well inside the window
    if (wd_service_i && cnt == 4'hf) begin
      next_ce = ~chip_en_o;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 4'h0;
      chip_en_o <= 1'b0;
    end else begin
      cnt <= next_cnt;
      chip_en_o <= next_ce;
    end
  end
endmodule
`default_nettype wire

// ---- rtcpw_pkg.sv ----
// constants shared by the rtc power and watchdog core
`default_nettype none
package rtcpw_pkg;
  localparam int CLK_MHZ = 20;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_SEC = 6'h20;
  localparam logic [5:0] IDX_MIN = 6'h21;
  localparam logic [5:0] IDX_HOUR = 6'h22;
  localparam logic [5:0] IDX_DOW = 6'h23;
  localparam logic [5:0] IDX_DATE = 6'h24;
  localparam logic [5:0] IDX_MONTH = 6'h25;
  localparam logic [5:0] IDX_YEAR = 6'h26;
  localparam logic [5:0] IDX_ASEC = 6'h28;
  localparam logic [5:0] IDX_AMIN = 6'h29;
  localparam logic [5:0] IDX_AHOUR = 6'h2a;
  localparam logic [5:0] IDX_STAT = 6'h30;
  localparam logic [5:0] IDX_CCTL = 6'h31;
  localparam logic [5:0] IDX_ICTL = 6'h32;
  localparam int IDX_RAM_SEL = 5;
  // clock control fields
  localparam int CC_START = 7;
  localparam int CC_LINE = 6;
  localparam int CC_XSEL = 4;
  localparam int CC_50HZ = 3;
  // interrupt control fields
  localparam int IC_WDOG = 7;
  localparam int IC_PDOWN = 6;
  localparam int IC_PSENSE = 5;
  localparam int IC_ALARM = 4;
  // status fields
  localparam int ST_WDOG = 6;
  localparam int ST_FIRST = 4;
  localparam int ST_PFAIL = 2;
  localparam int ST_ALARM = 1;
  localparam int ST_INT = 0;
  // hours fields
  localparam int HR_12H = 7;
  localparam int HR_PM = 5;
  localparam logic [7:0] CC_RST = 8'h00;
  localparam logic [7:0] IC_RST = 8'h00;
  localparam logic [7:0] ST_RST = 8'h10;
  localparam logic [7:0] TIME_RST = 8'h00;
  localparam logic [7:0] DAY_RST = 8'h01;
  // square wave select codes
  localparam logic [2:0] SQ_CRYSTAL_REF = 3'h0;
  localparam logic [2:0] SQ_DIV2 = 3'h1;
  localparam logic [2:0] SQ_DIV4 = 3'h2;
  localparam logic [2:0] SQ_DIV8 = 3'h3;
  localparam logic [2:0] SQ_LOW = 3'h4;
  localparam logic [2:0] SQ_1HZ = 3'h5;
  localparam logic [2:0] SQ_2HZ = 3'h6;
  localparam logic [2:0] SQ_LINE = 3'h7;
  // crystal rates by select code, and line rates
  localparam logic [22:0] CRYSTAL_REF_HZ0 = 23'h400000;
  localparam logic [22:0] CRYSTAL_REF_HZ1 = 23'h200000;
  localparam logic [22:0] CRYSTAL_REF_HZ2 = 23'h100000;
  localparam logic [22:0] CRYSTAL_REF_HZ3 = 23'h008000;
  localparam logic [5:0] LINE_HZ50 = 6'h32;
  localparam logic [5:0] LINE_HZ60 = 6'h3c;
  localparam int CRYSTAL_REF_SQ_HZ = 64;
  // timing
  localparam int ALARM_DLY_NS = 30500;
  localparam int ALARM_DLY_CYC = ALARM_DLY_NS * CLK_MHZ / 1000;
  localparam int PF_MIN_US = 2680;
  localparam int PF_MIN_CYC = PF_MIN_US * CLK_MHZ;
  localparam int WD_RST_US = 15600;
  localparam int WD_RST_CYC = WD_RST_US * CLK_MHZ;
  localparam int WD_PULSE_CYC = 16;
endpackage
`default_nettype wire

// ---- rtcpw_ram.sv ----
// 32 x 8 user ram with registered read data
`timescale 1ns/1ns
`default_nettype none
module rtcpw_ram #(
  parameter int AW = 5,
  parameter int DW = 8
) (
  input wire logic clk_i,
  input wire logic en_i,
  input wire logic we_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  output logic [DW-1:0] rdata_o
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk_i) begin
    if (en_i) begin
      if (we_i) begin
        mem[addr_i] <= wdata_i;
      end
      rdata_o <= mem[addr_i];
    end
  end
endmodule
`default_nettype wire

// ---- tb.sv ----
// testbench for the rtc power and watchdog core
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
  bad_count++; $display("ERROR %s expected %h seen %h", nm, ex, got); \
  end end
module tb;
  import rtcpw_pkg::*;
  localparam int TB_PF = 20;
  localparam int TB_WD = 40;
  localparam int LIMIT = 20000;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic sense = 1'b1;
  logic win = 1'b0;
  logic line_run = 1'b0;
  logic wd_srv = 1'b0;
  logic [31:0] dat_o;
  logic ack_o, supply_enable_out, hrst_oe, int_oe, sq, crystal_ref, line, ce;
  logic hrst_n, int_n;
  logic [7:0] q;
  int bad_count = 0;
  int n_checks = 0;
  int cycles = 0;
  int n;
  always #25 clk_i = ~clk_i;
  rtcpw_core #(.PF_CYC(TB_PF), .WD_CYC(TB_WD)) i_dut (.clk_i(clk_i),
    .rst_i(rst_i), .en_i(1'b1), .cyc_i(cyc), .stb_i(cyc), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
    .system_sense_in_i(sense), .line_in_window_i(win), .line_i(line),
    .crystal_ref_i(crystal_ref), .chip_en_i(ce), .supply_enable_out_o(supply_enable_out),
    .host_reset_n_o(hrst_n), .host_reset_oe_o(hrst_oe), .int_n_o(int_n),
    .int_oe_o(int_oe), .sq_wave_o(sq));
  rtcpw_host_env i_env (.clk_i(clk_i), .rst_i(rst_i), .line_run_i(line_run),
    .wd_service_i(wd_srv), .crystal_ref_o(crystal_ref), .line_o(line),
    .chip_en_o(ce));
  // ****
  // bus and helper tasks
  // ****
  task automatic bus(input logic [5:0] idx, input logic w,
                     input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    sel <= 4'h1;
    we <= w;
    adr <= {idx, 2'b00};
    dat <= {24'h0, d};
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    q = dat_o[7:0];
    cyc <= 1'b0;
    sel <= 4'h0;
    we <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] idx, input logic [7:0] ex);
    bus(idx, 1'b0, 8'h00);
    `CHK($sformatf("reg %h", idx), ex, q)
  endtask
  task automatic waitc(input int c);
    repeat (c) @(posedge clk_i);
  endtask
  task automatic poll_sec(input logic [7:0] v);
    n = 0;
    do begin
      bus(IDX_SEC, 1'b0, 8'h00);
      n++;
    end while (q !== v && n < 600);
  endtask
  // count clock-out rises over 64 cycles for one select code
  task automatic sq_rises(input logic [2:0] c, input int ex);
    int r;
    logic p;
    r = 0;
    bus(IDX_CCTL, 1'b1, {5'h00, c});
    rd(IDX_CCTL, {5'h00, c});
    p = sq;
    repeat (64) begin
      @(posedge clk_i);
      r += (sq === 1'b1 && p === 1'b0) ? 1 : 0;
      p = sq;
    end
    `CHK("clock out rises", ex, r)
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      bad_count++;
      close_out();
    end
  end
  // ****
  // tests
  // ****
  initial begin
    waitc(5);
    rst_i <= 1'b0;
    waitc(4);
    `CHK("supply enable", 1'b1, supply_enable_out)
    `CHK("host reset oe", 1'b0, hrst_oe)
    `CHK("open drain data", 2'b00, {hrst_n, int_n})
    rd(IDX_STAT, ST_RST);
    bus(IDX_STAT, 1'b1, 8'hff);
    rd(IDX_STAT, 8'h00);
    rd(IDX_CCTL, CC_RST);
    bus(IDX_ICTL, 1'b1, 8'h10);
    rd(IDX_ICTL, 8'h10);
    bus(6'h3f, 1'b1, 8'h5a);
    rd(6'h3f, 8'h00);
    bus(6'h00, 1'b1, 8'ha5);
    bus(6'h1f, 1'b1, 8'h3c);
    rd(6'h00, 8'ha5);
    rd(6'h1f, 8'h3c);
    rd(IDX_MONTH, DAY_RST);
    sq_rises(SQ_CRYSTAL_REF, 16);
    sq_rises(SQ_DIV2, 8);
    sq_rises(SQ_DIV4, 4);
    sq_rises(SQ_DIV8, 2);
    sq_rises(SQ_LOW, 0);
    $display("test registers done");
    bus(IDX_ICTL, 1'b1, 8'h00);
    bus(IDX_SEC, 1'b1, 8'h10);
    bus(IDX_ASEC, 1'b1, 8'h11);
    bus(IDX_CCTL, 1'b1, 8'hcc);
    line_run <= 1'b1;
    poll_sec(8'h11);
    `CHK("seconds", 8'h11, q)
    waitc(ALARM_DLY_CYC + 10);
    `CHK("int masked", 1'b0, int_oe)
    rd(IDX_STAT, 8'h02);
    bus(IDX_ICTL, 1'b1, 8'h10);
    bus(IDX_ASEC, 1'b1, 8'h13);
    poll_sec(8'h13);
    n = 0;
    while (int_oe !== 1'b1 && n < 1000) begin
      @(posedge clk_i);
      n++;
    end
    `CHK("alarm int", 1'b1, int_oe)
    `CHK("alarm delay", 1'b1, n >= ALARM_DLY_CYC - 12)
    rd(IDX_STAT, 8'h03);
    waitc(2);
    `CHK("int release", 1'b0, int_oe)
    line_run <= 1'b0;
    bus(IDX_ICTL, 1'b1, 8'h00);
    bus(IDX_CCTL, 1'b1, 8'h04);
    $display("test alarm done");
    bus(IDX_ICTL, 1'b1, 8'h40);
    waitc(2);
    `CHK("pd supply", 1'b0, supply_enable_out)
    `CHK("pd reset", 1'b1, hrst_oe)
    bus(6'h00, 1'b1, 8'h77);
    sense <= 1'b0;
    waitc(3);
    sense <= 1'b1;
    waitc(3);
    `CHK("pu supply", 1'b1, supply_enable_out)
    `CHK("pu reset", 1'b0, hrst_oe)
    rd(6'h00, 8'ha5);
    rd(IDX_ICTL, 8'h00);
    bus(IDX_ICTL, 1'b1, 8'h60);
    win <= 1'b1;
    waitc(TB_PF - 5);
    win <= 1'b0;
    waitc(5);
    `CHK("short window", 1'b0, int_oe)
    win <= 1'b1;
    n = 0;
    while (int_oe !== 1'b1 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    `CHK("pfail time", 1'b1, n >= TB_PF - 2 && n <= TB_PF + 4)
    waitc(2);
    `CHK("int release pd", 1'b1, supply_enable_out)
    win <= 1'b0;
    rd(IDX_STAT, 8'h05);
    $display("test power done");
    wd_srv <= 1'b1;
    bus(IDX_ICTL, 1'b1, 8'h80);
    waitc(200);
    `CHK("wd serviced", 1'b0, hrst_oe)
    wd_srv <= 1'b0;
    n = 0;
    while (hrst_oe !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    `CHK("wd fired", 1'b1, n >= TB_WD - 18 && n <= TB_WD + 20)
    waitc(20);
    `CHK("wd pulse end", 1'b0, hrst_oe)
    bus(IDX_ICTL, 1'b1, 8'h00);
    rd(IDX_STAT, 8'h40);
    $display("test watchdog done");
    sense <= 1'b0;
    rst_i <= 1'b1;
    waitc(5);
    rst_i <= 1'b0;
    waitc(4);
    `CHK("backup supply", 1'b0, supply_enable_out)
    `CHK("backup reset", 1'b1, hrst_oe)
    sense <= 1'b1;
    waitc(3);
    `CHK("backup up", 1'b1, supply_enable_out)
    sense <= 1'b0;
    waitc(3);
    `CHK("backup drop", 1'b0, supply_enable_out)
    $display("test backup done");
    close_out();
  end
endmodule
bind rtcpw_core rtcpw_core_chk i_chk (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
  .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .system_sense_in_i(system_sense_in_i),
  .supply_enable_out_o(supply_enable_out_o),
  .host_reset_oe_o(host_reset_oe_o), .int_oe_o(int_oe_o),
  .sq_wave_o(sq_wave_o));
`default_nettype wire
